// File: lbr_pkg.sv
// Purpose: Shared constants and types for the LED ramp timing block
// Assumes: 32-bit register words on byte addresses
// Notes: Offsets 0x00, 0x04 and 0x14 hold control, limit and status bits
package lbr_pkg;
    // Register byte offsets
    localparam logic [7:0] LBR_OFS_CTRL = 8'h00;
    localparam logic [7:0] LBR_OFS_LIMITS = 8'h04;
    localparam logic [7:0] LBR_OFS_HOLD = 8'h08;
    localparam logic [7:0] LBR_OFS_STEP = 8'h0C;
    localparam logic [7:0] LBR_OFS_STATUS = 8'h14;
    // Control register fields
    localparam int LBR_CTRL_MODE_LSB = 0;
    localparam int LBR_CTRL_WIDTH_LSB = 4;
    localparam int LBR_CTRL_COMMIT_BIT = 6;
    localparam int LBR_CTRL_MIRROR_BIT = 7;
    // Hold delay fields
    localparam int LBR_HOLD_W = 12;
    localparam int LBR_HOLD_TOP_LSB = 12;
    localparam int LBR_HOLD_BOT_LSB = 0;
    localparam logic [31:0] LBR_HOLD_MASK = 32'h00FF_FFFF;
    // Step fields
    localparam int LBR_STEP_W = 4;
    // Reset values
    localparam logic [31:0] LBR_RST_WORD = 32'h0000_0000;
    // Full-scale duty per width
    localparam logic [7:0] LBR_FULL_W8 = 8'hFF;
    localparam logic [7:0] LBR_FULL_W7 = 8'h7F;
    localparam logic [7:0] LBR_FULL_W6 = 8'h3F;
    typedef enum logic [1:0] {
        LBR_MODE_OFF, LBR_MODE_BREATHE, LBR_MODE_BLINK, LBR_MODE_ON
    } lbr_mode_t;
    typedef enum logic [1:0] {
        LBR_W8, LBR_W7, LBR_W6, LBR_WRSV
    } lbr_width_t;
    typedef enum logic [1:0] {
        LBR_RISE, LBR_TOP_HOLD, LBR_FALL, LBR_BOT_HOLD
    } lbr_ramp_t;
endpackage

// File: lbr_step_sel.sv
// Purpose: Segment index and scaled step for the duty ramp
// Assumes: Inputs come from registers on the same clock
// Notes: Purely combinational
`timescale 1ns/1ps
module lbr_step_sel import lbr_pkg::*; (
    // Configuration
    input wire logic [31:0] steps,
    input wire lbr_width_t width,
    input wire logic mirrored,
    // Ramp state
    input wire logic [7:0] duty,
    input wire logic falling,
    // Results
    output logic [2:0] seg,
    output logic [4:0] step
);
    logic [3:0] field;

    // Index, field pick and width scaling
    always_comb begin
        if (mirrored) begin
            seg = duty[7:5];
        end else begin
            seg = {falling, duty[7:6]};
        end
        field = steps[{seg, 2'b00} +: LBR_STEP_W];
        case (width)
            LBR_W7: step = {2'b00, field[3:1]} + 5'h01;
            LBR_W6: step = {3'b000, field[3:2]} + 5'h01;
            default: step = {1'b0, field} + 5'h01;
        endcase
    end
endmodule // lbr_step_sel

// File: lbr_ramp.sv
// Purpose: LED breathing ramp timing with double-buffered delays and steps
// Assumes: period_end is a one-cycle strobe from the PWM counter, same clock
// Notes: Avalon-MM slave, one wait cycle on every access
//
// Contract
// - Delay and step writes land in shadow
// - Reads return working copy, not shadow
// - Top hold waits N+1 periods, then decrement
// - Top hold 0 falls on next period end
// - Bottom hold waits N+1 periods, then increment
// - Blinking uses bottom field as prescaler
// - Eight 4-bit step fields, chosen per segment
// - Symmetric index is duty bits 7:5
// - Asymmetric index is falling, duty 7:6
// - 8-bit width: step is field plus one
// - 7-bit width: drop field bit 0
// - 6-bit width: drop field bits 1:0
// - Segment k field at bits 4k+3:4k
// - Commit set by writing one, hardware clears
// - Width codes 8, 7, 6 bit, reserved
// - Mode codes off, breathe, blink, on
`timescale 1ns/1ps
module lbr_ramp import lbr_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // PWM counter link
    input wire logic period_end,
    // Ramp outputs
    output logic [7:0] duty_cycle,
    output logic [11:0] blink_prescale
);
    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
        lbr_mode_t mode;
        lbr_width_t width;
        logic mirrored;
        logic commit;
        logic [7:0] lim_min;
        logic [7:0] lim_max;
        logic [23:0] hold_shadow;
        logic [23:0] hold_work;
        logic [31:0] step_shadow;
        logic [31:0] step_work;
        lbr_ramp_t state;
        logic [11:0] hold_cnt;
        logic [7:0] duty;
        logic [11:0] prescale;
    } lbr_state_t;

    lbr_state_t r;
    lbr_state_t next;
    logic rd_req;
    logic wr_acc;
    logic falling;
    logic [2:0] seg;
    logic [4:0] step;
    logic [7:0] full;
    logic [8:0] sum;
    logic [7:0] inc;
    logic [7:0] dec;
    logic [31:0] hold_rd;
    logic [11:0] top_field;
    logic [11:0] bot_field;

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] lbr_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Bus qualifiers and field views
    assign rd_req = read && r.waitrequest;
    assign wr_acc = write && !r.waitrequest;
    assign falling = (r.state == LBR_FALL) || (r.state == LBR_TOP_HOLD);
    assign hold_rd = {8'h00, r.hold_work};
    assign top_field = r.hold_work[LBR_HOLD_TOP_LSB +: LBR_HOLD_W];
    assign bot_field = r.hold_work[LBR_HOLD_BOT_LSB +: LBR_HOLD_W];

    // Segment and step from the working step word
    lbr_step_sel u_step (
        .steps(r.step_work),
        .width(r.width),
        .mirrored(r.mirrored),
        .duty(r.duty),
        .falling(falling),
        .seg(seg),
        .step(step)
    );

    // Full scale, clipped increment and floored decrement
    always_comb begin
        case (r.width)
            LBR_W7: full = LBR_FULL_W7;
            LBR_W6: full = LBR_FULL_W6;
            default: full = LBR_FULL_W8;
        endcase
        sum = {1'b0, r.duty} + {4'h0, step};
        if (sum > {1'b0, full}) begin
            inc = full;
        end else begin
            inc = sum[7:0];
        end
        if (r.duty > {3'b000, step}) begin
            dec = r.duty - {3'b000, step};
        end else begin
            dec = 8'h00;
        end
    end

    // Next-state logic: bus, commit and ramp
    always_comb begin
        next = r;
        next.waitrequest = 1'b1;
        // Answer one cycle after a request is seen
        if (rd_req || (write && r.waitrequest)) begin
            next.waitrequest = 1'b0;
            next.readdata = LBR_RST_WORD;
            if (read) begin
                if (address == LBR_OFS_CTRL) begin
                    next.readdata = {24'h00_0000, r.mirrored, r.commit,
                                     r.width, 2'b00, r.mode};
                end else if (address == LBR_OFS_LIMITS) begin
                    next.readdata = {16'h0000, r.lim_max, r.lim_min};
                end else if (address == LBR_OFS_HOLD) begin
                    next.readdata = hold_rd;
                end else if (address == LBR_OFS_STEP) begin
                    next.readdata = r.step_work;
                end else if (address == LBR_OFS_STATUS) begin
                    next.readdata = {18'h0_0000, r.state, 1'b0, seg, r.duty};
                end
            end
        end
        // Commit shadows at period end
        if (period_end && r.commit) begin
            next.hold_work = r.hold_shadow;
            next.step_work = r.step_shadow;
            next.commit = 1'b0;
        end
        // Register writes at the accepting edge
        if (wr_acc) begin
            if (address == LBR_OFS_CTRL) begin
                if (byteenable[0]) begin
                    next.mode = lbr_mode_t'(writedata[LBR_CTRL_MODE_LSB +: 2]);
                    next.width = lbr_width_t'(writedata[LBR_CTRL_WIDTH_LSB +: 2]);
                    next.mirrored = writedata[LBR_CTRL_MIRROR_BIT];
                    if (writedata[LBR_CTRL_COMMIT_BIT]) begin
                        next.commit = 1'b1;
                    end
                end
            end else if (address == LBR_OFS_LIMITS) begin
                if (byteenable[0]) begin
                    next.lim_min = writedata[7:0];
                end
                if (byteenable[1]) begin
                    next.lim_max = writedata[15:8];
                end
            end else if (address == LBR_OFS_HOLD) begin
                next.hold_shadow = 24'(lbr_merge({8'h00, r.hold_shadow},
                    writedata & LBR_HOLD_MASK, byteenable));
            end else if (address == LBR_OFS_STEP) begin
                next.step_shadow = lbr_merge(r.step_shadow, writedata,
                                             byteenable);
            end
        end
        // Prescaler only meaningful while blinking
        if (r.mode == LBR_MODE_BLINK) begin
            next.prescale = bot_field;
        end else begin
            next.prescale = 12'h000;
        end
        // Ramp per mode
        case (r.mode)
            LBR_MODE_OFF: begin
                next.duty = 8'h00;
                next.state = LBR_RISE;
                next.hold_cnt = 12'h000;
            end
            LBR_MODE_BLINK: begin
                next.duty = r.lim_min;
                next.state = LBR_RISE;
                next.hold_cnt = 12'h000;
            end
            LBR_MODE_ON: begin
                next.duty = full;
            end
            default: begin
                if (period_end) begin
                    case (r.state)
                        LBR_RISE: begin
                            if (r.duty >= r.lim_max) begin
                                next.state = LBR_TOP_HOLD;
                                next.hold_cnt = top_field;
                            end else begin
                                next.duty = inc;
                            end
                        end
                        LBR_TOP_HOLD: begin
                            if (r.hold_cnt == 12'h000) begin
                                next.state = LBR_FALL;
                                next.duty = dec;
                            end else begin
                                next.hold_cnt = r.hold_cnt - 12'h001;
                            end
                        end
                        LBR_FALL: begin
                            if (r.duty <= r.lim_min) begin
                                next.state = LBR_BOT_HOLD;
                                next.hold_cnt = bot_field;
                            end else begin
                                next.duty = dec;
                            end
                        end
                        default: begin
                            if (r.hold_cnt == 12'h000) begin
                                next.state = LBR_RISE;
                                next.duty = inc;
                            end else begin
                                next.hold_cnt = r.hold_cnt - 12'h001;
                            end
                        end
                    endcase
                end
            end
        endcase
    end

    // State register with synchronous reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            r <= '0;
            r.waitrequest <= 1'b1;
        end else begin
            r <= next;
        end
    end

    // Outputs straight from flops
    assign readdata = r.readdata;
    assign waitrequest = r.waitrequest;
    assign duty_cycle = r.duty;
    assign blink_prescale = r.prescale;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence commit_ev;
        period_end && r.commit && !wr_acc;
    endsequence
    sequence reach_top;
        r.mode == LBR_MODE_BREATHE && period_end && r.state == LBR_RISE
            && r.duty >= r.lim_max;
    endsequence
    sequence reach_bot;
        r.mode == LBR_MODE_BREATHE && period_end && r.state == LBR_FALL
            && r.duty <= r.lim_min;
    endsequence

    shadow_hold_a: assert property (
        wr_acc && address == LBR_OFS_HOLD && !(period_end && r.commit)
        |=> $stable(r.hold_work))
        else $error("hold write reached working copy");
    commit_copy_a: assert property (
        commit_ev |=> r.hold_work == $past(r.hold_shadow)
            && r.step_work == $past(r.step_shadow) && !r.commit)
        else $error("commit did not copy shadows");
    read_work_a: assert property (
        rd_req && address == LBR_OFS_HOLD
        |=> !waitrequest && readdata == $past(hold_rd))
        else $error("hold read not working copy");
    top_hold_a: assert property (
        reach_top |=> r.state == LBR_TOP_HOLD
            && r.hold_cnt == $past(top_field) && $stable(r.duty))
        else $error("top hold not loaded");
    hold_bypass_a: assert property (
        r.mode == LBR_MODE_BREATHE && period_end && r.state == LBR_TOP_HOLD
        && r.hold_cnt == 12'h000 && !wr_acc |=> r.state == LBR_FALL)
        else $error("top hold did not end");
    bottom_hold_a: assert property (
        reach_bot |=> r.state == LBR_BOT_HOLD
            && r.hold_cnt == $past(bot_field))
        else $error("bottom hold not loaded");
    blink_prescale_a: assert property (
        r.mode == LBR_MODE_BLINK |=> blink_prescale == $past(bot_field))
        else $error("prescaler not bottom field");
    seg_index_a: assert property (
        r.mirrored |-> seg == r.duty[7:5])
        else $error("symmetric index wrong");
    asym_index_a: assert property (
        !r.mirrored |-> seg == {falling, r.duty[7:6]})
        else $error("asymmetric index wrong");
    step_range_a: assert property (
        r.width == LBR_W6 |-> step >= 5'h01 && step <= 5'h04)
        else $error("6-bit step out of range");
endmodule // lbr_ramp

// File: lbr_ramp_tb.sv
// Purpose: Self-checking bench for the LED ramp timing block
// Assumes: Avalon-MM slave answers by lowering waitrequest, period_end is a pulse
// Notes: Ramp expectations come from a small reference model kept in this file
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module testbench import lbr_pkg::*; ;
    // Clock, reset and bus signals
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0] byteenable = 4'h0;
    logic period_end = 1'b0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [7:0] duty_cycle;
    logic [11:0] blink_prescale;
    int fail_count = 0;
    int total_checks = 0;
    // Reference model state
    int m_w, m_mir, m_max, m_min, m_top, m_bot, m_duty, m_st, m_cnt;
    logic [31:0] m_steps;
    logic [7:0] fulls [4] = '{LBR_FULL_W8, LBR_FULL_W7, LBR_FULL_W6, LBR_FULL_W8};

    // 200 MHz clock
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    lbr_ramp dut (.clk_sys(clk_sys), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .period_end(period_end),
        .duty_cycle(duty_cycle), .blink_prescale(blink_prescale));

    // Verdict and end of run
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One bus access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                       output logic [31:0] rdata);
        int n;
        @(posedge clk_sys);
        address <= addr;
        writedata <= data;
        byteenable <= 4'hF;
        read <= ~wr;
        write <= wr;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0) begin
            fail_count++;
            $display("[ERR] t=%0t bus wait timed out got=%h exp=%h", $time, waitrequest, 1'b0);
            print_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] dummy;
        bus(1'b1, addr, data, dummy);
    endtask

    task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] got;
        bus(1'b0, addr, 32'h0000_0000, got);
        `CHK(got, exp)
    endtask

    // One PWM period end, result settled on return
    task automatic period_pulse();
        @(posedge clk_sys);
        period_end <= 1'b1;
        @(posedge clk_sys);
        period_end <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Scaled step for the current segment
    function automatic int step_of();
        int seg;
        int f;
        seg = m_mir ? m_duty[7:5] : {(m_st == 1 || m_st == 2), m_duty[7:6]};
        f = m_steps[4 * seg +: 4];
        return (m_w == 1) ? (f >> 1) + 1 : (m_w == 2) ? (f >> 2) + 1 : f + 1;
    endfunction

    // Model of one period end in breathing mode
    task automatic model_period();
        int s;
        int full;
        s = step_of();
        full = fulls[m_w];
        if (m_st == 0 && m_duty >= m_max) begin
            m_st = 1;
            m_cnt = m_top;
        end else if (m_st == 2 && m_duty <= m_min) begin
            m_st = 3;
            m_cnt = m_bot;
        end else if ((m_st == 1 || m_st == 3) && m_cnt != 0) begin
            m_cnt--;
        end else if (m_st == 1 || m_st == 2) begin
            m_st = 2;
            m_duty = (m_duty > s) ? m_duty - s : 0;
        end else begin
            m_st = 0;
            m_duty = (m_duty + s > full) ? full : m_duty + s;
        end
    endtask

    // Configure, commit, then follow the ramp period by period
    task automatic run_cfg(int w, int mir, int mx, int mn, int top, int bot, int periods);
        logic [31:0] ctl;
        m_w = w;
        m_mir = mir;
        m_max = mx;
        m_min = mn;
        m_top = top;
        m_bot = bot;
        m_steps = 32'h9B3D_2F61;
        ctl = {24'h00_0000, mir[0], 1'b0, w[1:0], 4'h0};
        wr(LBR_OFS_CTRL, ctl);
        wr(LBR_OFS_LIMITS, {16'h0000, mx[7:0], mn[7:0]});
        wr(LBR_OFS_HOLD, {8'h00, top[11:0], bot[11:0]});
        wr(LBR_OFS_STEP, m_steps);
        wr(LBR_OFS_CTRL, ctl | 32'h0000_0040);
        period_pulse();
        `CHK(duty_cycle, 8'h00)
        wr(LBR_OFS_CTRL, ctl | 32'h0000_0001);
        rdchk(LBR_OFS_CTRL, ctl | 32'h0000_0001);
        m_duty = 0;
        m_st = 0;
        repeat (periods) begin
            period_pulse();
            model_period();
            `CHK(duty_cycle, m_duty[7:0])
        end
        // Status view: ramp state, segment index and duty at the end of the run
        rdchk(LBR_OFS_STATUS, {18'h0_0000, m_st[1:0], 1'b0,
            ((m_mir != 0) ? m_duty[7:5] : {(m_st == 1 || m_st == 2), m_duty[7:6]}),
            m_duty[7:0]});
        $display("Ramp test width %0d mirrored %0d done", w, mir);
    endtask

    // Main sequence
    initial begin
        logic [31:0] rd;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset values and an unmapped address
        rdchk(LBR_OFS_HOLD, LBR_RST_WORD);
        rdchk(LBR_OFS_STEP, LBR_RST_WORD);
        rdchk(8'h20, 32'h0000_0000);
        $display("Reset value test done");
        // Shadowed writes stay hidden until a committed period end
        wr(LBR_OFS_HOLD, 32'hFFAB_C123);
        wr(LBR_OFS_STEP, 32'h1234_5678);
        period_pulse();
        rdchk(LBR_OFS_HOLD, LBR_RST_WORD);
        rdchk(LBR_OFS_STEP, LBR_RST_WORD);
        wr(LBR_OFS_CTRL, 32'h0000_0040);
        wr(LBR_OFS_CTRL, 32'h0000_0000);
        bus(1'b0, LBR_OFS_CTRL, 32'h0000_0000, rd);
        `CHK(rd[6], 1'b1)
        rdchk(LBR_OFS_HOLD, LBR_RST_WORD);
        period_pulse();
        rdchk(LBR_OFS_HOLD, 32'hFFAB_C123 & LBR_HOLD_MASK);
        rdchk(LBR_OFS_STEP, 32'h1234_5678);
        bus(1'b0, LBR_OFS_CTRL, 32'h0000_0000, rd);
        `CHK(rd[6], 1'b0)
        $display("Commit test done");
        // Every width and mode code, blink prescaler from bottom field
        wr(LBR_OFS_LIMITS, 32'h0000_C035);
        for (int w = 0; w < 4; w++) begin
            for (int m = 0; m < 4; m++) begin
                wr(LBR_OFS_CTRL, {24'h00_0000, 2'b00, w[1:0], 2'b00, m[1:0]});
                repeat (2) @(posedge clk_sys);
                `CHK(duty_cycle, (m == 3) ? fulls[w] : (m == 2) ? 8'h35 : 8'h00)
                `CHK(blink_prescale, (m == 2) ? 12'h123 : 12'h000)
            end
        end
        $display("Mode and width test done");
        run_cfg(0, 1, 8'hF0, 8'h10, 1, 0, 70);
        run_cfg(0, 0, 8'hE0, 8'h20, 0, 2, 70);
        run_cfg(1, 1, 8'h70, 8'h04, 3, 1, 70);
        run_cfg(2, 0, 8'h38, 8'h02, 0, 0, 70);
        run_cfg(3, 0, 8'hC0, 8'h40, 4095, 4095, 8300);
        print_verdict();
    end
endmodule // testbench
